// ===== hdl/bacu_defs.svh
// Purpose: Constants of the byte add/add-with-carry unit
// Assumes: Included by bare name from hdl/
// Notes: Definitions only
`ifndef BACU_DEFS_SVH
`define BACU_DEFS_SVH

// Opcode high nibbles
`define BACU_OPC_ADD 4'h0
`define BACU_OPC_ADC 4'h1

// Opcode low nibbles, one per addressing form
`define BACU_MODE_WW 4'h2
`define BACU_MODE_WPW 4'h3
`define BACU_MODE_FF 4'h4
`define BACU_MODE_FPF 4'h5
`define BACU_MODE_FL 4'h6
`define BACU_MODE_PL 4'h7

// Operand byte high nibble that selects a working register
`define BACU_WREG_NIBBLE 4'hE

// Instruction lengths in core clock cycles
`define BACU_CYC_WORKING 6
`define BACU_CYC_FULL 10

// Reset values
`define BACU_RST_BYTE 8'h00
`define BACU_RST_CNT 4'h0

`endif

// ===== hdl/bacu_pkg.sv
// Purpose: Types of the byte add/add-with-carry unit
// Assumes: Used by scoped name only
// Notes: Sequencer states are one-hot
package bacu_pkg;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_PTR = 6'h02,
    ST_SRC = 6'h04,
    ST_DST = 6'h08,
    ST_HOLD = 6'h10,
    ST_WRITE = 6'h20
  } bacu_state_type;

endpackage : bacu_pkg

// ===== hdl/bacu_adder.sv
// Purpose: Sum and arithmetic flags of two operands plus carry-in
// Assumes: Pure combinational, WIDTH of at least 5
// Notes: Half carry is the carry out of bit 3
`timescale 1ns/1ps
module bacu_adder #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] a_i,
  input wire logic [WIDTH-1:0] b_i,
  input wire logic cin_i,
  output logic [WIDTH-1:0] sum_o,
  output logic carry_o,
  output logic half_o,
  output logic overflow_o,
  output logic zero_o,
  output logic sign_o
);

  if (WIDTH < 5) begin : g_width_check
    $error("bacu_adder: WIDTH must be at least 5");
  end

  logic [WIDTH:0] full_sum;
  logic [4:0] nib_sum;

  // Full and low-nibble sums
  assign full_sum = {1'b0, a_i} + {1'b0, b_i} + {{WIDTH{1'b0}}, cin_i};
  assign nib_sum = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};

  // Flags from the sum
  assign sum_o = full_sum[WIDTH-1:0];
  assign carry_o = full_sum[WIDTH];
  assign half_o = nib_sum[4];
  assign zero_o = (full_sum[WIDTH-1:0] == '0);
  assign sign_o = full_sum[WIDTH-1];
  assign overflow_o = (a_i[WIDTH-1] == b_i[WIDTH-1]) && (full_sum[WIDTH-1] != a_i[WIDTH-1]);

endmodule : bacu_adder

// ===== hdl/bacu_core.sv
// Purpose: Sequencer of the byte add and add-with-carry instructions
// Assumes: Register file read data is valid in the cycle its address is shown
// Notes: Function
// Function
// - ADD stores dst+src in dst, src untouched
// - ADC adds current carry as carry-in
// - Carry flag is carry out of bit 7
// - Zero flag set when stored sum is zero
// - Sign flag follows bit 7 of sum
// - Overflow on same-sign operands, opposite-sign sum
// - Half carry is carry out of bit 3
// - ADD opcodes 02-07, 6 or 10 cycles
// - ADC opcodes 12-17, same forms and cycles
// - Register forms: opcode, source byte, destination byte
// - Literal forms: opcode, destination byte, literal value
// - Pointer destination holds address of target register
// - High nibble 1110b selects a working register
// - Working forms: dst upper nibble, src lower
`timescale 1ns/1ps
`include "bacu_defs.svh"
module bacu_core #(
  parameter int CYC_WORKING = `BACU_CYC_WORKING,
  parameter int CYC_FULL = `BACU_CYC_FULL
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic start_i,
  input wire logic [7:0] opcode_i,
  input wire logic [7:0] operand1_i,
  input wire logic [7:0] operand2_i,
  input wire logic [3:0] reg_pointer_i,
  input wire logic carry_i,
  input wire logic [7:0] rf_rdata_i,
  output logic busy_o,
  output logic done_o,
  output logic [7:0] rf_addr_o,
  output logic rf_we_o,
  output logic [7:0] rf_wdata_o,
  output logic flags_we_o,
  output logic flag_c_o,
  output logic flag_z_o,
  output logic flag_s_o,
  output logic flag_v_o,
  output logic flag_d_o,
  output logic flag_h_o
);

  if (CYC_WORKING < 6 || CYC_FULL < 6 || CYC_WORKING > 15 || CYC_FULL > 15) begin : g_cyc_check
    $error("bacu_core: cycle counts must lie in 6..15");
  end

  localparam logic [3:0] LAST_WORKING = 4'(CYC_WORKING - 2);
  localparam logic [3:0] LAST_FULL = 4'(CYC_FULL - 2);

  // Operand byte to register address, with working-register escape
  function automatic logic [7:0] full_addr(input logic [7:0] b, input logic [3:0] rp);
    full_addr = (b[7:4] == `BACU_WREG_NIBBLE) ? {rp, b[3:0]} : b;
  endfunction : full_addr

  bacu_pkg::bacu_state_type state_q;
  logic [3:0] mode_q;
  logic [7:0] op1_q;
  logic [7:0] op2_q;
  logic [3:0] rp_q;
  logic cin_q;
  logic [7:0] src_q;
  logic [7:0] dst_q;
  logic [7:0] ptr_q;
  logic [3:0] cnt_q;
  logic [7:0] addr_q;
  logic busy_q;
  logic done_q;
  logic we_q;
  logic [7:0] wdata_q;
  logic c_q;
  logic z_q;
  logic s_q;
  logic v_q;
  logic d_q;
  logic h_q;

  // Opcode decode at the request port
  wire [3:0] in_mode = opcode_i[3:0];
  wire in_opc_ok = (opcode_i[7:4] == `BACU_OPC_ADD) || (opcode_i[7:4] == `BACU_OPC_ADC);
  wire in_mode_ok = (in_mode >= `BACU_MODE_WW) && (in_mode <= `BACU_MODE_PL);
  wire start_acc = start_i && !busy_q && in_opc_ok && in_mode_ok;
  wire in_indirect = (in_mode == `BACU_MODE_WPW) || (in_mode == `BACU_MODE_FPF) || (in_mode == `BACU_MODE_PL);
  wire in_lit = (in_mode == `BACU_MODE_FL) || (in_mode == `BACU_MODE_PL);
  wire in_adc = (opcode_i[7:4] == `BACU_OPC_ADC);

  // Address of the first read of each form
  wire [7:0] in_ptr_addr = (in_mode == `BACU_MODE_WPW) ? {reg_pointer_i, operand1_i[3:0]} :
                           full_addr(operand1_i, reg_pointer_i);
  wire [7:0] in_src_addr = (in_mode == `BACU_MODE_WW) ? {reg_pointer_i, operand1_i[3:0]} :
                           full_addr(operand1_i, reg_pointer_i);
  wire [7:0] first_addr = in_indirect ? in_ptr_addr :
                          (in_mode == `BACU_MODE_FL) ? full_addr(operand1_i, reg_pointer_i) : in_src_addr;

  // Destination address from the held instruction bytes, or from the fetched pointer for PL
  wire q_working = (mode_q == `BACU_MODE_WW) || (mode_q == `BACU_MODE_WPW);
  wire [7:0] dst_addr = q_working ? {rp_q, op1_q[7:4]} :
                        (mode_q == `BACU_MODE_PL) ? ptr_q :
                        (mode_q == `BACU_MODE_FL) ? full_addr(op1_q, rp_q) :
                        full_addr(op2_q, rp_q);
  wire last_cycle = (cnt_q == (q_working ? LAST_WORKING : LAST_FULL));

  logic [7:0] sum;
  logic sum_c;
  logic sum_h;
  logic sum_v;
  logic sum_z;
  logic sum_s;

  bacu_adder #(.WIDTH(8)) u_adder (
    .a_i(dst_q),
    .b_i(src_q),
    .cin_i(cin_q),
    .sum_o(sum),
    .carry_o(sum_c),
    .half_o(sum_h),
    .overflow_o(sum_v),
    .zero_o(sum_z),
    .sign_o(sum_s)
  );

  // Sequencer: fetch pointer, source, destination, then wait
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= bacu_pkg::ST_IDLE;
      mode_q <= `BACU_MODE_WW;
      op1_q <= `BACU_RST_BYTE;
      op2_q <= `BACU_RST_BYTE;
      rp_q <= `BACU_RST_CNT;
      cin_q <= 1'b0;
      src_q <= `BACU_RST_BYTE;
      dst_q <= `BACU_RST_BYTE;
      ptr_q <= `BACU_RST_BYTE;
      cnt_q <= `BACU_RST_CNT;
      addr_q <= `BACU_RST_BYTE;
      busy_q <= 1'b0;
    end else begin
      cnt_q <= busy_q ? cnt_q + 4'h1 : 4'h1;
      case (state_q)
        bacu_pkg::ST_IDLE: begin
          if (start_acc) begin
            mode_q <= in_mode;
            op1_q <= operand1_i;
            op2_q <= operand2_i;
            rp_q <= reg_pointer_i;
            cin_q <= in_adc ? carry_i : 1'b0;
            src_q <= operand2_i; // Literal source
            addr_q <= first_addr;
            busy_q <= 1'b1;
            state_q <= in_indirect ? bacu_pkg::ST_PTR :
                       in_lit ? bacu_pkg::ST_DST : bacu_pkg::ST_SRC;
          end
        end
        bacu_pkg::ST_PTR: begin
          ptr_q <= rf_rdata_i;
          addr_q <= rf_rdata_i; // Pointer content is the next address
          state_q <= (mode_q == `BACU_MODE_PL) ? bacu_pkg::ST_DST : bacu_pkg::ST_SRC;
        end
        bacu_pkg::ST_SRC: begin
          src_q <= rf_rdata_i;
          addr_q <= dst_addr;
          state_q <= bacu_pkg::ST_DST;
        end
        bacu_pkg::ST_DST: begin
          dst_q <= rf_rdata_i;
          state_q <= bacu_pkg::ST_HOLD;
        end
        bacu_pkg::ST_HOLD: begin
          if (last_cycle) begin
            state_q <= bacu_pkg::ST_WRITE;
          end
        end
        bacu_pkg::ST_WRITE: begin
          busy_q <= 1'b0;
          state_q <= bacu_pkg::ST_IDLE;
        end
        default: begin
          busy_q <= 1'b0;
          state_q <= bacu_pkg::ST_IDLE;
        end
      endcase
    end
  end

  wire commit = (state_q == bacu_pkg::ST_HOLD) && last_cycle;

  // Result and flags registered together for the final cycle
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      done_q <= 1'b0;
      we_q <= 1'b0;
      wdata_q <= `BACU_RST_BYTE;
      c_q <= 1'b0;
      z_q <= 1'b0;
      s_q <= 1'b0;
      v_q <= 1'b0;
      d_q <= 1'b0;
      h_q <= 1'b0;
    end else begin
      done_q <= commit;
      we_q <= commit;
      if (commit) begin
        wdata_q <= sum;
        c_q <= sum_c;
        z_q <= sum_z;
        s_q <= sum_s;
        v_q <= sum_v;
        d_q <= 1'b0;
        h_q <= sum_h;
      end
    end
  end

  // Outputs straight from flip-flops
  assign busy_o = busy_q;
  assign done_o = done_q;
  assign rf_addr_o = addr_q; // Destination stays shown during the write
  assign rf_we_o = we_q;
  assign rf_wdata_o = wdata_q;
  assign flags_we_o = we_q;
  assign flag_c_o = c_q;
  assign flag_z_o = z_q;
  assign flag_s_o = s_q;
  assign flag_v_o = v_q;
  assign flag_d_o = d_q;
  assign flag_h_o = h_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  wire acc_working = start_acc && ((in_mode == `BACU_MODE_WW) || (in_mode == `BACU_MODE_WPW));
  wire acc_full = start_acc && !((in_mode == `BACU_MODE_WW) || (in_mode == `BACU_MODE_WPW));
  wire [8:0] chk_sum = {1'b0, dst_q} + {1'b0, src_q} + {8'h00, cin_q};
  wire [4:0] chk_nib = {1'b0, dst_q[3:0]} + {1'b0, src_q[3:0]} + {4'h0, cin_q};

  sequence s_quiet4;
    !done_o [*4];
  endsequence

  a_working_length: assert property (acc_working |-> ##1 s_quiet4 ##1 done_o)
    else $error("working form did not finish in its cycle count");
  a_full_length: assert property (acc_full |-> ##1 s_quiet4 ##1 s_quiet4 ##1 done_o)
    else $error("full form did not finish in its cycle count");
  a_commit_together: assert property (done_o |-> rf_we_o && flags_we_o && busy_o ##1 !busy_o)
    else $error("result and flags not written together");
  a_sum_carry: assert property (flags_we_o |-> {flag_c_o, rf_wdata_o} == chk_sum)
    else $error("sum or carry wrong");
  a_zero_sign: assert property (flags_we_o |-> flag_z_o == (rf_wdata_o == 8'h00) && flag_s_o == rf_wdata_o[7])
    else $error("zero or sign flag wrong");
  a_overflow_half: assert property (flags_we_o |-> flag_v_o == ((dst_q[7] == src_q[7]) && (rf_wdata_o[7] != dst_q[7]))
                                    && flag_h_o == chk_nib[4])
    else $error("overflow or half carry wrong");
  a_decimal_clear: assert property (flags_we_o |-> !flag_d_o)
    else $error("decimal-adjust flag not cleared");
  a_working_dst: assert property (start_acc && in_mode == `BACU_MODE_WW |->
                                  ##5 rf_addr_o == {$past(reg_pointer_i, 5), $past(operand1_i[7:4], 5)})
    else $error("working destination address wrong");
  a_adc_carry_in: assert property (start_acc |=> cin_q == ($past(in_adc) && $past(carry_i)))
    else $error("carry-in not taken from carry flag");

endmodule : bacu_core

// ===== sim/bacu_regfile.sv
// Purpose: Register file model at the far side of the add unit
// Assumes: Read data follows the address in the same cycle
// Notes: Counts every write so that stray writes show up
`timescale 1ns/1ps
module bacu_regfile (
  input wire logic clk_i,
  input wire logic [7:0] addr_i,
  input wire logic we_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [256];
  int writes = 0;
  // Combinational read of the shown address
  assign rdata_o = mem[addr_i];
  // Write on the edge that ends a write cycle
  always @(posedge clk_i) begin
    if (we_i === 1'b1) begin
      mem[addr_i] <= wdata_i;
      writes <= writes + 1;
    end
  end
endmodule : bacu_regfile

// ===== sim/testbench.sv
// Purpose: Self-checking bench of the byte add unit
// Assumes: Working register bank 2, stimulus 1 ns after the rising edge
// Notes: Expected sums and flags are worked out here
`timescale 1ns/1ps
module testbench;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic start_i = 1'b0;
  logic [7:0] opcode_i = 8'h00;
  logic [7:0] operand1_i = 8'h00;
  logic [7:0] operand2_i = 8'h00;
  logic [3:0] reg_pointer_i = 4'h2;
  logic carry_i = 1'b0;
  logic [7:0] rf_rdata, rf_addr, rf_wdata;
  logic busy, done, rf_we, flags_we, fc, fz, fs, fv, fd, fh;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;

  bacu_core i_bacu_core (.clk_i(clk_i), .reset_i(reset_i), .start_i(start_i), .opcode_i(opcode_i),
    .operand1_i(operand1_i), .operand2_i(operand2_i), .reg_pointer_i(reg_pointer_i), .carry_i(carry_i),
    .rf_rdata_i(rf_rdata), .busy_o(busy), .done_o(done), .rf_addr_o(rf_addr), .rf_we_o(rf_we),
    .rf_wdata_o(rf_wdata), .flags_we_o(flags_we), .flag_c_o(fc), .flag_z_o(fz), .flag_s_o(fs),
    .flag_v_o(fv), .flag_d_o(fd), .flag_h_o(fh));
  bacu_regfile i_bacu_regfile (.clk_i(clk_i), .addr_i(rf_addr), .we_i(rf_we), .wdata_i(rf_wdata),
    .rdata_o(rf_rdata));

  // Clock and hang guard
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One instruction, with a refused second request while busy
  task automatic run(input logic [7:0] opc, op1, op2, input logic cin, input logic [7:0] da, a, b);
    logic cy;
    logic [8:0] s9;
    logic [4:0] h5;
    int n;
    int w0;
    cy = opc[4] & cin;
    s9 = {1'b0, a} + {1'b0, b} + {8'h00, cy};
    h5 = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cy};
    w0 = i_bacu_regfile.writes;
    opcode_i = opc;
    operand1_i = op1;
    operand2_i = op2;
    carry_i = cin;
    start_i = 1'b1;
    @(posedge clk_i);
    #1;
    start_i = 1'b0;
    chk({7'h00, busy}, 8'h01);
    n = 1;
    while (done !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      #1;
      n++;
      start_i = (n == 2);
    end
    chk(8'(n), (opc[3:0] < 4'h4) ? 8'h05 : 8'h09);
    chk(rf_addr, da);
    chk(rf_wdata, s9[7:0]);
    chk({2'b00, fc, fz, fs, fv, fd, fh}, {2'b00, s9[8], s9[7:0] == 8'h00, s9[7],
      (a[7] == b[7]) && (s9[7] != a[7]), 1'b0, h5[4]});
    chk({6'h00, rf_we, flags_we}, 8'h03);
    @(posedge clk_i);
    #1;
    chk(i_bacu_regfile.mem[da], s9[7:0]);
    chk({6'h00, done, rf_we}, 8'h00);
    chk(8'(i_bacu_regfile.writes - w0), 8'h01);
  endtask : run

  // Preload pointer, source and destination, then run
  task automatic ex(input logic [7:0] opc, op1, op2, input logic cin, input logic [7:0] da, a, pa, pv, sa, b);
    i_bacu_regfile.mem[pa] = pv;
    i_bacu_regfile.mem[sa] = b;
    i_bacu_regfile.mem[da] = a;
    run(opc, op1, op2, cin, da, a, b);
  endtask : ex

  // Plain add, all six forms, carry input ignored on one
  task automatic t_add_forms();
    ex(8'h02, 8'h3B, 8'h00, 1'b0, 8'h23, 8'h16, 8'h23, 8'h16, 8'h2B, 8'h20);
    ex(8'h03, 8'hFA, 8'h00, 1'b0, 8'h2F, 8'h16, 8'h2A, 8'h20, 8'h20, 8'h11);
    ex(8'h04, 8'h12, 8'h34, 1'b1, 8'h34, 8'h2E, 8'h34, 8'h2E, 8'h12, 8'h1B);
    ex(8'h05, 8'hE3, 8'h4B, 1'b0, 8'h4B, 8'h82, 8'h23, 8'h10, 8'h10, 8'h01);
    ex(8'h06, 8'h6C, 8'h03, 1'b0, 8'h6C, 8'h2A, 8'h6C, 8'h2A, 8'h6C, 8'h03);
    ex(8'h07, 8'hD4, 8'h02, 1'b0, 8'h5F, 8'h4C, 8'hD4, 8'h5F, 8'h5F, 8'h02);
  endtask : t_add_forms

  // Add with carry, all six forms, back to back
  task automatic t_adc_forms();
    ex(8'h12, 8'h3B, 8'h00, 1'b1, 8'h23, 8'h16, 8'h23, 8'h16, 8'h2B, 8'h20);
    ex(8'h13, 8'hFA, 8'h00, 1'b0, 8'h2F, 8'h16, 8'h2A, 8'h20, 8'h20, 8'h11);
    ex(8'h14, 8'h12, 8'h34, 1'b1, 8'h34, 8'h2E, 8'h34, 8'h2E, 8'h12, 8'h1B);
    ex(8'h15, 8'hE3, 8'h4B, 1'b1, 8'h4B, 8'h82, 8'h23, 8'h10, 8'h10, 8'h01);
    ex(8'h16, 8'h6C, 8'h03, 1'b0, 8'h6C, 8'h2A, 8'h6C, 8'h2A, 8'h6C, 8'h03);
    ex(8'h17, 8'hD4, 8'h02, 1'b1, 8'h5F, 8'h4C, 8'hD4, 8'h5F, 8'h5F, 8'h02);
  endtask : t_adc_forms

  // Carry, zero, overflow and sign corners; working register as destination
  task automatic t_flag_edges();
    ex(8'h04, 8'h12, 8'h34, 1'b0, 8'h34, 8'h80, 8'h34, 8'h80, 8'h12, 8'h80);
    ex(8'h16, 8'h6C, 8'h00, 1'b1, 8'h6C, 8'hFF, 8'h6C, 8'hFF, 8'h6C, 8'h00);
    ex(8'h04, 8'h12, 8'hE5, 1'b0, 8'h25, 8'h7F, 8'h25, 8'h7F, 8'h12, 8'h01);
  endtask : t_flag_edges

  // Invalid opcodes start nothing
  task automatic t_refused();
    logic [7:0] bad [4] = '{8'h01, 8'h08, 8'h22, 8'h1A};
    int w0;
    foreach (bad[k]) begin
      w0 = i_bacu_regfile.writes;
      opcode_i = bad[k];
      start_i = 1'b1;
      @(posedge clk_i);
      #1;
      start_i = 1'b0;
      chk({7'h00, busy}, 8'h00);
      repeat (12) @(posedge clk_i);
      #1;
      chk(8'(i_bacu_regfile.writes - w0), 8'h00);
    end
  endtask : t_refused

  // Reset in mid-instruction drops it; then another working bank
  task automatic t_reset_mid();
    int w0;
    w0 = i_bacu_regfile.writes;
    opcode_i = 8'h04;
    start_i = 1'b1;
    @(posedge clk_i);
    #1;
    start_i = 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    reset_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    chk({5'h00, busy, done, rf_we}, 8'h00);
    reset_i = 1'b0;
    repeat (12) @(posedge clk_i);
    #1;
    chk(8'(i_bacu_regfile.writes - w0), 8'h00);
    reg_pointer_i = 4'hA;
    ex(8'h02, 8'h3B, 8'h00, 1'b0, 8'hA3, 8'h16, 8'hA3, 8'h16, 8'hAB, 8'h20);
    ex(8'h15, 8'hE3, 8'h4B, 1'b1, 8'h4B, 8'h82, 8'hA3, 8'h10, 8'h10, 8'h01);
    reg_pointer_i = 4'h2;
  endtask : t_reset_mid

  // Main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    chk({6'h00, busy, done}, 8'h00);
    t_add_forms();
    t_adc_forms();
    t_flag_edges();
    t_refused();
    t_reset_mid();
    wrap_up();
  end
endmodule : testbench
